//--- include/dsv_cfg.svh
// Address map, field positions, reset values and time bases of the supervisor.
// Assumes a 25 MHz system clock and word-aligned AXI4-Lite accesses.
`ifndef DSV_CFG_SVH
`define DSV_CFG_SVH
`define DSV_CLK_NS      40
`define DSV_TICK_NS     1000000
`define DSV_HOUR_TICKS  3600000
`define DSV_DISP_TICKS  1000
// Register byte offsets
`define DSV_A_CTRL      9'h000
`define DSV_A_STAT      9'h004
`define DSV_A_CMD       9'h008
`define DSV_A_SIMC      9'h00c
`define DSV_A_SRESP     9'h010
`define DSV_A_SSTOP     9'h014
`define DSV_A_HRS_E     9'h018
`define DSV_A_HRS_S     9'h01c
`define DSV_A_TMR       9'h020
`define DSV_TMR_STEP    9'h010
`define DSV_A_SIM       9'h040
`define DSV_SIM_STEP    9'h020
// Control, command and simulation-control bits; reset values and bus responses
`define DSV_B_COMM      0
`define DSV_B_TWEN      1
`define DSV_B_TIEN      3
`define DSV_B_SATEN     5
`define DSV_B_SATIE     6
`define DSV_B_INTHI     7
`define DSV_B_FDIR      8
`define DSV_B_MMR       4
`define DSV_B_SRAMP     3
`define DSV_B_SFALL     6
`define DSV_CTRL_RST    32'h0000_0000
`define DSV_MIN_RST     16'hffff
`define DSV_MAX_RST     16'h0000
`define DSV_RESP_OK     2'h0
`define DSV_RESP_ERR    2'h2
`endif

//--- include/dsv_pkg.sv
// Types shared by the diagnostic supervisor.
// Assumes dsv_cfg.svh is on the include path.
package dsv_pkg;
  typedef enum logic [1:0] {
    DSV_CMD_NONE = 2'b00,
    DSV_CMD_RST  = 2'b01,
    DSV_CMD_ACK  = 2'b10,
    DSV_CMD_DEA  = 2'b11
  } dsv_cmd_t;
  typedef enum logic [1:0] {
    DSV_FD_ACT  = 2'b00,
    DSV_FD_INV  = 2'b01,
    DSV_FD_SAT  = 2'b10,
    DSV_FD_ISAT = 2'b11
  } dsv_fdir_t;
  typedef struct packed {
    logic [31:0]       ctrl;
    logic [8:0]        simc;
    logic [1:0][31:0]  t1, t2, tcnt;
    logic [1:0]        twarn, tint, tack;
    logic [31:0]       sresp, sstop, srcnt, sscnt;
    logic              sevt, sdir;
    logic [2:0][15:0]  fix, lo, hi, steps, dur, dcnt, val, mn, mx;
    logic [2:0]        ron;
    logic [31:0]       tdiv, hdiv, dph;
    logic              tick, init, disp, warn, fault, fhi, nvs, pf_q;
    logic [1:0]        pf_s;
    logic [1:0][31:0]  hrs;
    logic [15:0]       pout;
    logic              aw_f, w_f, bv, rv;
    logic [8:0]        aw_a;
    logic [31:0]       wd, rd;
    logic [3:0]        ws;
    logic [1:0]        br, rr;
  } dsv_st_t;
endpackage : dsv_pkg

//--- design/dsv_top.sv
// Diagnostic supervisor: warnings, interrupts, timers, saturation, simulation.
// Assumes measurement and saturation inputs are on CLK; PWR_FAIL is a pin.
`timescale 1ns/1ns
`default_nettype none
`include "dsv_cfg.svh"
module dsv_top
  import dsv_pkg::*;
#(
  parameter int TICK_CYC   = `DSV_TICK_NS / `DSV_CLK_NS,
  parameter int HOUR_TICKS = `DSV_HOUR_TICKS,
  parameter int DISP_TICKS = `DSV_DISP_TICKS
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [8:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [8:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic [15:0] PRESS_IN,
  input  wire logic [15:0] TSENS_IN,
  input  wire logic [15:0] TELEC_IN,
  input  wire logic        SAT_HI,
  input  wire logic        SAT_LO,
  input  wire logic        PWR_FAIL,
  input  wire logic [31:0] NV_HRS_E,
  input  wire logic [31:0] NV_HRS_S,
  output logic [31:0]      HRS_E,
  output logic [31:0]      HRS_S,
  output logic             NV_SAVE,
  output logic [15:0]      PRESS_OUT,
  output logic             FAULT_CUR,
  output logic             FAULT_HI,
  output logic             DIAG_WARN,
  output logic             DISP_MSG,
  output logic             DISP_ERR
);
  dsv_st_t  q, s;
  dsv_cmd_t tcmd [2];
  logic        mmr, sat, wgo, sfault;
  logic [31:0] wv;
  logic [32:0] rdw, rdr;
  logic [15:0] eff [3];
  logic [15:0] inc;
  logic [16:0] nxt;

  // ==========================================================================
  // Register read decode, bit 32 marks a mapped address
  function automatic logic [32:0] rd_f(input dsv_st_t r, input logic [8:0] a);
    logic [32:0] v;
    v = {1'b0, 32'h0000_0000};
    if (a == `DSV_A_CTRL) v = {1'b1, r.ctrl};
    else if (a == `DSV_A_STAT)
      v = {1'b1, 24'h00_0000, r.fhi, r.sevt, r.tint, r.twarn, r.fault, r.warn};
    else if (a == `DSV_A_CMD) v = {1'b1, 32'h0000_0000};
    else if (a == `DSV_A_SIMC) v = {1'b1, 23'h00_0000, r.simc};
    else if (a == `DSV_A_SRESP) v = {1'b1, r.sresp};
    else if (a == `DSV_A_SSTOP) v = {1'b1, r.sstop};
    else if (a == `DSV_A_HRS_E) v = {1'b1, r.hrs[0]};
    else if (a == `DSV_A_HRS_S) v = {1'b1, r.hrs[1]};
    for (int i = 0; i < 2; i++) begin
      if (a == `DSV_A_TMR + 9'(i) * `DSV_TMR_STEP) v = {1'b1, r.t1[i]};
      else if (a == `DSV_A_TMR + 9'(i) * `DSV_TMR_STEP + 9'h004) v = {1'b1, r.t2[i]};
      else if (a == `DSV_A_TMR + 9'(i) * `DSV_TMR_STEP + 9'h008) v = {1'b1, r.tcnt[i]};
    end
    for (int p = 0; p < 3; p++) begin
      if (a[8:5] == 4'(2 + p)) begin
        case (a[4:2])
          3'h0: v = {17'h1_0000, r.fix[p]};
          3'h1: v = {17'h1_0000, r.lo[p]};
          3'h2: v = {17'h1_0000, r.hi[p]};
          3'h3: v = {17'h1_0000, r.steps[p]};
          3'h4: v = {17'h1_0000, r.dur[p]};
          3'h5: v = {17'h1_0000, r.val[p]};
          3'h6: v = {17'h1_0000, r.mn[p]};
          default: v = {17'h1_0000, r.mx[p]};
        endcase
      end
    end
    return v;
  endfunction : rd_f

  // Bus handshakes straight from the state
  assign AWREADY = !q.aw_f && !q.bv;
  assign WREADY  = !q.w_f && !q.bv;
  assign ARREADY = !q.rv;
  assign BVALID  = q.bv;
  assign BRESP   = q.br;
  assign RVALID  = q.rv;
  assign RRESP   = q.rr;
  assign RDATA   = q.rd;

  // Outputs from registered state
  assign HRS_E     = q.hrs[0];
  assign HRS_S     = q.hrs[1];
  assign NV_SAVE   = q.nvs;
  assign PRESS_OUT = q.pout;
  assign FAULT_CUR = q.fault;
  assign FAULT_HI  = q.fhi;
  assign DIAG_WARN = q.warn;
  assign DISP_MSG  = q.disp;
  assign DISP_ERR  = q.fault;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    s      = q;
    mmr    = 1'b0;
    tcmd[0] = DSV_CMD_NONE;
    tcmd[1] = DSV_CMD_NONE;
    wv     = q.wd;
    inc    = 16'h0000;
    nxt    = 17'h0_0000;
    sat    = SAT_HI || SAT_LO;
    wgo    = q.aw_f && q.w_f && !q.bv;
    rdw    = rd_f(q, q.aw_a);
    rdr    = rd_f(q, ARADDR);
    for (int b = 0; b < 4; b++) begin
      wv[8*b +: 8] = q.ws[b] ? q.wd[8*b +: 8] : rdw[8*b +: 8];
    end
    eff[0] = q.simc[0] ? q.val[0] : PRESS_IN;
    eff[1] = q.simc[1] ? q.val[1] : TSENS_IN;
    eff[2] = q.simc[2] ? q.val[2] : TELEC_IN;

    // Common timebase tick
    s.tick = 1'b0;
    if (q.tdiv >= 32'(TICK_CYC - 1)) begin
      s.tdiv = 32'h0000_0000;
      s.tick = 1'b1;
    end else s.tdiv = q.tdiv + 32'h0000_0001;

    // Power-fail sync, save pulse and restore at start
    s.pf_s = {q.pf_s[0], PWR_FAIL};
    s.pf_q = q.pf_s[1];
    s.nvs  = q.pf_s[1] && !q.pf_q;
    if (!q.init) begin
      s.init   = 1'b1;
      s.hrs[0] = NV_HRS_E;
      s.hrs[1] = NV_HRS_S;
    end else if (q.tick && q.ctrl[`DSV_B_COMM]) begin
      if (q.hdiv >= 32'(HOUR_TICKS - 1)) begin
        s.hdiv   = 32'h0000_0000;
        s.hrs[0] = q.hrs[0] + 32'h0000_0001;
        s.hrs[1] = q.hrs[1] + 32'h0000_0001;
      end else s.hdiv = q.hdiv + 32'h0000_0001;
    end

    // Bus capture and write decode
    if (AWVALID && AWREADY) begin
      s.aw_f = 1'b1;
      s.aw_a = AWADDR;
    end
    if (WVALID && WREADY) begin
      s.w_f = 1'b1;
      s.wd  = WDATA;
      s.ws  = WSTRB;
    end
    if (BVALID && BREADY) s.bv = 1'b0;
    if (wgo) begin
      s.aw_f = 1'b0;
      s.w_f  = 1'b0;
      s.bv   = 1'b1;
      s.br   = rdw[32] ? `DSV_RESP_OK : `DSV_RESP_ERR;
      if (q.aw_a == `DSV_A_CTRL) begin
        s.ctrl = wv | (q.ctrl & 32'h0000_0001); // commissioning is sticky
      end else if (q.aw_a == `DSV_A_CMD) begin
        tcmd[0] = dsv_cmd_t'(wv[1:0]);
        tcmd[1] = dsv_cmd_t'(wv[3:2]);
        mmr     = wv[`DSV_B_MMR];
      end else if (q.aw_a == `DSV_A_SIMC) s.simc = wv[8:0];
      else if (q.aw_a == `DSV_A_SRESP) s.sresp = wv;
      else if (q.aw_a == `DSV_A_SSTOP) s.sstop = wv;
      for (int i = 0; i < 2; i++) begin
        if (q.aw_a == `DSV_A_TMR + 9'(i) * `DSV_TMR_STEP) s.t1[i] = wv;
        else if (q.aw_a == `DSV_A_TMR + 9'(i) * `DSV_TMR_STEP + 9'h004) s.t2[i] = wv;
      end
      for (int p = 0; p < 3; p++) begin
        if (q.aw_a[8:5] == 4'(2 + p)) begin
          case (q.aw_a[4:2])
            3'h0: s.fix[p] = wv[15:0];
            3'h1: s.lo[p] = wv[15:0];
            3'h2: s.hi[p] = wv[15:0];
            3'h3: s.steps[p] = wv[15:0];
            3'h4: s.dur[p] = wv[15:0];
            default: ;
          endcase
        end
      end
    end
    // Read channel
    if (RVALID && RREADY) s.rv = 1'b0;
    if (ARVALID && ARREADY) begin
      s.rv = 1'b1;
      s.rd = rdr[31:0];
      s.rr = rdr[32] ? `DSV_RESP_OK : `DSV_RESP_ERR;
    end

    // Calibration and service timers
    for (int i = 0; i < 2; i++) begin
      if (q.tick && q.ctrl[`DSV_B_TWEN + i]) s.tcnt[i] = q.tcnt[i] + 32'h0000_0001;
      if (tcmd[i] == DSV_CMD_RST) begin
        s.tcnt[i] = 32'h0000_0000;
        s.twarn[i] = 1'b0;
        s.tint[i]  = 1'b0;
        s.tack[i]  = 1'b0;
      end else if (tcmd[i] == DSV_CMD_ACK) begin
        if (q.tcnt[i] >= q.t1[i]) begin
          s.twarn[i] = 1'b0;
          s.tint[i]  = 1'b0;
          s.tack[i]  = 1'b1;
        end
      end else if (tcmd[i] == DSV_CMD_DEA) begin
        s.tcnt[i]  = 32'h0000_0000;
        s.twarn[i] = 1'b0;
        s.tint[i]  = 1'b0;
        s.tack[i]  = 1'b0;
        s.ctrl[`DSV_B_TWEN + i] = 1'b0;
      end else if (q.ctrl[`DSV_B_TWEN + i] && !q.tack[i]) begin
        if (q.tcnt[i] == q.t1[i]) s.twarn[i] = 1'b1;
        if (q.ctrl[`DSV_B_TIEN + i] && q.tcnt[i] == q.t1[i] + q.t2[i]) begin
          s.tint[i] = 1'b1;
        end
      end
    end

    // Current saturation monitor
    if (!q.ctrl[`DSV_B_SATEN]) begin
      s.sevt  = 1'b0;
      s.srcnt = 32'h0000_0000;
      s.sscnt = 32'h0000_0000;
    end else if (!q.sevt) begin
      if (!sat) s.srcnt = 32'h0000_0000;
      else if (q.srcnt >= q.sresp) begin
        s.sevt  = 1'b1;
        s.sscnt = 32'h0000_0000;
        s.sdir  = SAT_HI;
      end else if (q.tick) s.srcnt = q.srcnt + 32'h0000_0001;
    end else if (q.sscnt >= q.sstop) begin
      if (!sat) begin
        s.sevt  = 1'b0;
        s.srcnt = 32'h0000_0000;
      end
    end else if (q.tick) s.sscnt = q.sscnt + 32'h0000_0001;

    // Fault current, direction and warning
    sfault  = q.sevt && q.ctrl[`DSV_B_SATIE];
    s.fault = sfault || (|q.tint);
    s.warn  = q.sevt || (|q.twarn) || (|q.tint);
    s.fhi   = q.ctrl[`DSV_B_INTHI];
    if (sfault) begin
      case (dsv_fdir_t'(q.ctrl[`DSV_B_FDIR +: 2]))
        DSV_FD_ACT:  s.fhi = q.ctrl[`DSV_B_INTHI];
        DSV_FD_INV:  s.fhi = !q.ctrl[`DSV_B_INTHI];
        DSV_FD_SAT:  s.fhi = q.sdir;
        default:     s.fhi = !q.sdir;
      endcase
    end

    // Display alternation while a warning stands
    if (!q.warn) begin
      s.disp = 1'b0;
      s.dph  = 32'h0000_0000;
    end else if (q.tick) begin
      if (q.dph >= 32'(DISP_TICKS - 1)) begin
        s.dph  = 32'h0000_0000;
        s.disp = !q.disp;
      end else s.dph = q.dph + 32'h0000_0001;
    end

    // Simulation paths, fixed or ramp
    for (int p = 0; p < 3; p++) begin
      inc = (q.hi[p] - q.lo[p]) / ((q.steps[p] == 16'h0000) ? 16'h0001 : q.steps[p]);
      if (!q.simc[p] || !q.simc[`DSV_B_SRAMP + p]) begin
        s.val[p] = q.fix[p];
        s.ron[p] = 1'b0;
        s.dcnt[p] = 16'h0000;
      end else if (!q.ron[p]) begin
        s.ron[p] = 1'b1;
        s.val[p] = q.simc[`DSV_B_SFALL + p] ? q.hi[p] : q.lo[p];
      end else if (q.tick) begin
        if (q.dcnt[p] + 16'h0001 >= q.dur[p]) begin
          s.dcnt[p] = 16'h0000;
          if (!q.simc[`DSV_B_SFALL + p]) begin
            nxt = {1'b0, q.val[p]} + {1'b0, inc};
            s.val[p] = (nxt > {1'b0, q.hi[p]}) ? q.lo[p] : nxt[15:0];
          end else begin
            nxt = {1'b0, q.val[p]} - {1'b0, inc};
            s.val[p] = (nxt[16] || nxt[15:0] < q.lo[p]) ? q.hi[p] : nxt[15:0];
          end
        end else s.dcnt[p] = q.dcnt[p] + 16'h0001;
      end
      // Peak pointers follow the effective value
      if (mmr) begin
        s.mn[p] = eff[p];
        s.mx[p] = eff[p];
      end else begin
        if (eff[p] < q.mn[p]) s.mn[p] = eff[p];
        if (eff[p] > q.mx[p]) s.mx[p] = eff[p];
      end
    end
    s.pout = eff[0];
  end

  // ==========================================================================
  // State register; simulation settings are volatile
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      q      <= '0;
      q.ctrl <= `DSV_CTRL_RST;
      q.mn   <= {3{`DSV_MIN_RST}};
      q.mx   <= {3{`DSV_MAX_RST}};
    end else q <= s;
  end

  // ==========================================================================
  // Checks
  int unsigned cdeep;
  localparam int DLY_LO = 1;
  localparam int DLY_HI = 3;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) cdeep <= 0;
    else cdeep <= (q.fault && q.sevt) ? cdeep + 1 : 0;
  end
  a_ctrl_default: assert property (@(posedge CLK) $past(RESET) && !RESET |-> q.ctrl == 32'h0)
    else $error("control not cleared by reset");
  a_sat_fault: assert property (@(posedge CLK) disable iff (RESET)
    $rose(q.sevt) && q.ctrl[`DSV_B_SATIE] |-> ##[DLY_LO:DLY_HI] FAULT_CUR)
    else $error("saturation interrupt without fault current");
  a_sat_early: assert property (@(posedge CLK) disable iff (RESET)
    $rose(q.sevt) |-> $past(sat) && $past(q.srcnt) >= $past(q.sresp))
    else $error("saturation interrupt before response time");
  a_sat_hold: assert property (@(posedge CLK) disable iff (RESET)
    $fell(q.sevt) && $past(q.ctrl[`DSV_B_SATEN]) |-> $past(q.sscnt) >= $past(q.sstop) && !$past(sat))
    else $error("saturation interrupt dropped early");
  a_tmr_deact: assert property (@(posedge CLK) disable iff (RESET)
    tcmd[0] == DSV_CMD_DEA |=> q.tcnt[0] == 32'h0 && !q.ctrl[`DSV_B_TWEN] && !q.twarn[0])
    else $error("deactivate left timer running");
  a_tmr_ack: assert property (@(posedge CLK) disable iff (RESET)
    tcmd[0] == DSV_CMD_ACK && q.tcnt[0] >= q.t1[0] |=> q.tack[0] && !q.tint[0] ##1 !q.twarn[0])
    else $error("acknowledge after limit failed");
  a_hours_keep: assert property (@(posedge CLK) disable iff (RESET)
    q.init && $past(q.init) |-> q.hrs[0] >= $past(q.hrs[0]))
    else $error("hours counter went backwards");
  a_press_sim: assert property (@(posedge CLK) disable iff (RESET)
    $past(q.simc[0]) |-> PRESS_OUT == $past(q.val[0]))
    else $error("pressure output ignores simulation");
  a_bus_hold: assert property (@(posedge CLK) disable iff (RESET)
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  c_sat_fault: cover property (@(posedge CLK) disable iff (RESET) $rose(q.sevt) ##[1:5] FAULT_CUR);
  c_tmr_warn: cover property (@(posedge CLK) disable iff (RESET) $rose(q.twarn[0]));
  c_ramp: cover property (@(posedge CLK) disable iff (RESET) q.ron[0] && $changed(q.val[0]));
  c_sat_hold: cover property (@(posedge CLK) disable iff (RESET) cdeep == 32'd4);
endmodule : dsv_top
`default_nettype wire

//--- tb/dsv_host_model.sv
// Host model: the remote master that configures the supervisor over AXI4-Lite.
// Assumes CLK is the supervisor clock; the bench calls wr and rd in turn.
`timescale 1ns/1ns
`default_nettype none
module dsv_host_model (
  input  wire logic        CLK,
  output logic [8:0]       AWADDR,
  output logic             AWVALID,
  input  wire logic        AWREADY,
  output logic [31:0]      WDATA,
  output logic [3:0]       WSTRB,
  output logic             WVALID,
  input  wire logic        WREADY,
  input  wire logic [1:0]  BRESP,
  input  wire logic        BVALID,
  output logic             BREADY,
  output logic [8:0]       ARADDR,
  output logic             ARVALID,
  input  wire logic        ARREADY,
  input  wire logic [31:0] RDATA,
  input  wire logic [1:0]  RRESP,
  input  wire logic        RVALID,
  output logic             RREADY
);
  // ==========
  // Idle bus
  initial begin
    {AWADDR, AWVALID, WDATA, WSTRB, WVALID, BREADY} = '0;
    {ARADDR, ARVALID, RREADY} = '0;
  end
  // ==========
  // One write; payload scrambled once taken so stale data never looks valid
  // Response accepted one cycle late, so the slave must hold it meanwhile
  task automatic wr(input logic [8:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b, hold;
    b = 1'b0;
    @(posedge CLK);
    {AWADDR, WDATA, WSTRB} <= {a, d, 4'hf};
    {AWVALID, WVALID} <= 2'b11;
    while (!b) begin
      @(negedge CLK);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      b = BVALID && BREADY;
      hold = BVALID && !BREADY;
      r = BRESP;
      @(posedge CLK);
      if (aw) {AWVALID, AWADDR} <= {1'b0, ~a};
      if (w) {WVALID, WDATA} <= {1'b0, ~d};
      if (b) BREADY <= 1'b0;
      if (hold) BREADY <= 1'b1;
    end
  endtask : wr
  // ==========
  // One read
  task automatic rd(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    v = 1'b0;
    @(posedge CLK);
    {ARADDR, ARVALID, RREADY} <= {a, 2'b11};
    while (!v) begin
      @(negedge CLK);
      ar = ARVALID && ARREADY;
      v = RVALID && RREADY;
      {d, r} = {RDATA, RRESP};
      @(posedge CLK);
      if (ar) {ARVALID, ARADDR} <= {1'b0, ~a};
      if (v) RREADY <= 1'b0;
    end
  endtask : rd
endmodule : dsv_host_model
`default_nettype wire

//--- tb/test_dsv_top.sv
// Self-checking bench of the diagnostic supervisor.
// Assumes dsv_cfg.svh on the include path and a shortened timebase.
`timescale 1ns/1ns
`default_nettype none
`include "dsv_cfg.svh"
module test_dsv_top import dsv_pkg::*; ;
  localparam logic [8:0] CMDA = `DSV_A_CMD;
  localparam logic [8:0] TCNT = `DSV_A_TMR + 9'h8;
  localparam logic [8:0] SIM = `DSV_A_SIM;
  logic        CLK, RESET, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, SAT_HI, SAT_LO, PWR_FAIL, NV_SAVE;
  logic        FAULT_CUR, FAULT_HI, DIAG_WARN, DISP_MSG, DISP_ERR;
  logic [8:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, NV_HRS_E, NV_HRS_S, HRS_E, HRS_S, d, c;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, r;
  logic [15:0] PRESS_IN, TSENS_IN, TELEC_IN, PRESS_OUT, pv;
  int          errors, comparisons, i;
  dsv_top #(.TICK_CYC(4), .HOUR_TICKS(3), .DISP_TICKS(2)) u_dut (
    .CLK, .RESET, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
    .RREADY, .PRESS_IN, .TSENS_IN, .TELEC_IN, .SAT_HI, .SAT_LO, .PWR_FAIL, .NV_HRS_E,
    .NV_HRS_S, .HRS_E, .HRS_S, .NV_SAVE, .PRESS_OUT, .FAULT_CUR, .FAULT_HI,
    .DIAG_WARN, .DISP_MSG, .DISP_ERR);
  dsv_host_model u_m (
    .CLK, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP,
    .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
  // ==========
  // Clock, helpers
  always #20 CLK = ~CLK;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    u_m.wr(a, v, r);
  endtask : wr
  task automatic rdc(input string n, input logic [8:0] a, input logic [31:0] e);
    u_m.rd(a, d, r);
    chk(n, e, d);
  endtask : rdc
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask : cyc
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // ==========
  // Watchdog
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    summarize();
  end
  // ==========
  // Tests
  initial begin
    {CLK, RESET, SAT_HI, SAT_LO, PWR_FAIL} = 5'b01000;
    {NV_HRS_E, NV_HRS_S} = {32'h5, 32'h9};
    {PRESS_IN, TSENS_IN, TELEC_IN} = {16'h0100, 16'h0200, 16'h0300};
    {errors, comparisons} = '0;
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    cyc(20);
    chk("hrs_idle", 32'h5, HRS_E);
    rdc("ctrl_rst", `DSV_A_CTRL, `DSV_CTRL_RST);
    chk("warn_rst", 0, DIAG_WARN | FAULT_CUR);
    u_m.rd(9'h1fc, d, r);
    chk("rresp", `DSV_RESP_ERR, r);
    u_m.wr(9'h1fc, 32'h0, r);
    chk("bresp", `DSV_RESP_ERR, r);
    wr(`DSV_A_CTRL, 32'h1);
    cyc(40);
    chk("hrs_e_run", 1, HRS_E > 6 && HRS_E < 10);
    chk("hrs_s_run", 1, HRS_S > 10 && HRS_S < 14);
    u_m.wr(`DSV_A_HRS_E, 32'h0, r);
    chk("bresp_ro", `DSV_RESP_OK, r);
    cyc(1);
    chk("hrs_kept", 1, HRS_E > 6);
    @(posedge CLK);
    PWR_FAIL <= 1'b1;
    for (i = 0; i < 8 && !NV_SAVE; i++) @(negedge CLK);
    chk("nv_save", 1, NV_SAVE);
    @(posedge CLK);
    PWR_FAIL <= 1'b0;
    $display("test hours done");
    wr(`DSV_A_TMR, 32'd20);
    wr(`DSV_A_TMR + 9'h4, 32'd4);
    wr(`DSV_A_CTRL, 32'hb);
    cyc(20);
    u_m.rd(TCNT, c, r);
    wr(CMDA, 32'(DSV_CMD_ACK));
    u_m.rd(TCNT, d, r);
    chk("cnt_ack", 1, d > c);
    wr(CMDA, 32'(DSV_CMD_RST));
    u_m.rd(TCNT, d, r);
    chk("cnt_rst", 1, d < 3);
    for (i = 0; i < 200 && !DIAG_WARN; i++) @(negedge CLK);
    chk("warn_t1", 1, DIAG_WARN && i > 60);
    chk("no_fault", 0, FAULT_CUR);
    c = 32'(DISP_MSG);
    for (i = 0; i < 12 && DISP_MSG === c[0]; i++) @(negedge CLK);
    chk("disp_alt", !c[0], DISP_MSG);
    for (i = 0; i < 40 && !FAULT_CUR; i++) @(negedge CLK);
    chk("fault_t2", 1, FAULT_CUR);
    chk("disp_err", 1, DISP_ERR);
    u_m.rd(`DSV_A_STAT, d, r);
    chk("stat", 32'h17, d & 32'h7f);
    wr(CMDA, 32'(DSV_CMD_ACK));
    cyc(1);
    chk("ack_clear", 0, DIAG_WARN | FAULT_CUR);
    u_m.rd(TCNT, c, r);
    cyc(60);
    chk("ack_quiet", 0, DIAG_WARN | FAULT_CUR);
    u_m.rd(TCNT, d, r);
    chk("ack_runs", 1, d > c + 10);
    wr(CMDA, 32'(DSV_CMD_RST));
    for (i = 0; i < 200 && !DIAG_WARN; i++) @(negedge CLK);
    chk("rst_rearm", 1, DIAG_WARN && i > 60);
    wr(CMDA, 32'(DSV_CMD_DEA));
    cyc(1);
    chk("dea_warn", 0, DIAG_WARN);
    rdc("dea_ctrl", `DSV_A_CTRL, 32'h9);
    cyc(20);
    rdc("dea_cnt", TCNT, 32'h0);
    $display("test timer done");
    wr(`DSV_A_SRESP, 32'd3);
    wr(`DSV_A_SSTOP, 32'd5);
    for (int f = 0; f < 4; f++) begin
      wr(`DSV_A_CTRL, 32'h0e1 | (f << 8));
      @(posedge CLK);
      SAT_LO <= 1'b1;
      for (i = 0; i < 40 && !FAULT_CUR; i++) @(negedge CLK);
      chk("sat_fault", 1, FAULT_CUR && i > 10);
      chk("sat_dir", f == 0 || f == 3, FAULT_HI);
      @(posedge CLK);
      SAT_LO <= 1'b0;
      cyc(8);
      chk("sat_hold", 1, FAULT_CUR);
      for (i = 0; i < 40 && FAULT_CUR; i++) @(negedge CLK);
      chk("sat_drop", 0, FAULT_CUR);
    end
    @(posedge CLK);
    SAT_HI <= 1'b1;
    cyc(6);
    @(posedge CLK);
    SAT_HI <= 1'b0;
    c = '0;
    repeat (40) begin
      @(negedge CLK);
      c = c | 32'(FAULT_CUR);
    end
    chk("sat_short", 0, c);
    $display("test saturation done");
    wr(SIM, 32'h1234);
    wr(SIM + `DSV_SIM_STEP, 32'h55);
    wr(`DSV_A_SIMC, 32'h7);
    @(posedge CLK);
    PRESS_IN <= 16'h0777;
    cyc(2);
    chk("sim_fix", 16'h1234, PRESS_OUT);
    rdc("sim_ts", SIM + `DSV_SIM_STEP + 9'h14, 32'h55);
    wr(SIM + 9'h4, 32'h10);
    wr(SIM + 9'h8, 32'h40);
    wr(SIM + 9'hc, 32'h3);
    wr(SIM + 9'h10, 32'h2);
    wr(`DSV_A_SIMC, 32'h3f);
    cyc(12);
    wr(CMDA, 32'h10);
    cyc(1);
    pv = PRESS_OUT;
    repeat (100) begin
      @(negedge CLK);
      if (PRESS_OUT !== pv) chk("ramp", 1, PRESS_OUT == pv + 16'h10 || PRESS_OUT == 16'h10);
      pv = PRESS_OUT;
    end
    rdc("peak_min", SIM + 9'h18, 32'h10);
    rdc("peak_max", SIM + 9'h1c, 32'h40);
    @(posedge CLK);
    RESET <= 1'b1;
    @(posedge CLK);
    RESET <= 1'b0;
    rdc("simc_rst", `DSV_A_SIMC, 32'h0);
    cyc(1);
    chk("press_rst", 16'h0777, PRESS_OUT);
    $display("test simulation done");
    summarize();
  end
endmodule : test_dsv_top
`default_nettype wire
